// ### inc/tso_pkg.sv
package tso_pkg;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W  = 5;
  localparam int unsigned NPINS  = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_PIN_CFG = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_SELECT  = 8'h0B;

  // field positions
  localparam int unsigned SEL_A_LSB = 0;
  localparam int unsigned SEL_B_LSB = 8;
  localparam int unsigned CFG_A_LSB = 0;
  localparam int unsigned CFG_B_LSB = 8;
  localparam int unsigned CFG_INV   = 0;
  localparam int unsigned CFG_OD    = 1;
  localparam int unsigned CFG_EN    = 2;

  // values after reset and writable bits
  localparam logic [REG_W-1:0] SEL_REG_RST  = 16'h0000;
  localparam logic [REG_W-1:0] SEL_REG_MASK = 16'h1F1F;
  localparam logic [REG_W-1:0] CFG_REG_RST  = 16'h0404;
  localparam logic [REG_W-1:0] CFG_REG_MASK = 16'h0707;

  typedef enum logic [4:0] {
    SEL_IRQ    = 5'h01,
    SEL_WINDOW = 5'h02,
    SEL_LED_A  = 5'h05,
    SEL_LED_B  = 5'h06,
    SEL_LED_AB = 5'h07,
    SEL_WR_A   = 5'h0C,
    SEL_WR_B   = 5'h0D,
    SEL_WR_AB  = 5'h0E,
    SEL_HALF   = 5'h0F,
    SEL_LOW    = 5'h10,
    SEL_HIGH   = 5'h11,
    SEL_OSC    = 5'h13
  } tso_sel_t;

  typedef enum logic [0:0] {
    WIN_IDLE = 1'b0,
    WIN_OPEN = 1'b1
  } tso_win_t;
endpackage

// ### inc/tso_if.sv
`timescale 1ns/1ns
interface tso_if;
  logic sample_win;
  logic led_a;
  logic led_b;
  logic wr_a;
  logic wr_b;
  logic half_rate;
  logic osc;
  logic irq;

  modport src  (output sample_win, led_a, led_b, wr_a, wr_b, half_rate, osc, irq);
  modport sink (input  sample_win, led_a, led_b, wr_a, wr_b, half_rate, osc, irq);
endinterface

// ### core/tso_pin_sel.sv
`timescale 1ns/1ns
module tso_pin_sel
  import tso_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic [tso_pkg::SEL_W-1:0] sel,
  input  wire logic                      invert,
  input  wire logic                      open_drain,
  input  wire logic                      enable,
  tso_if.sink                            tif,
  output logic                           pin_out,
  output logic                           pin_oe_n
);
  import tso_pkg::*;

  logic raw;
  logic nxt_oe_n;

  always_comb begin
    case (sel)
      SEL_IRQ:    raw = tif.irq;
      SEL_WINDOW: raw = tif.sample_win;
      SEL_LED_A:  raw = tif.led_a;
      SEL_LED_B:  raw = tif.led_b;
      SEL_LED_AB: raw = tif.led_a | tif.led_b;
      SEL_WR_A:   raw = tif.wr_a;
      SEL_WR_B:   raw = tif.wr_b;
      SEL_WR_AB:  raw = tif.wr_a | tif.wr_b;
      SEL_HALF:   raw = tif.half_rate;
      SEL_LOW:    raw = 1'b0;
      SEL_HIGH:   raw = 1'b1;
      SEL_OSC:    raw = tif.osc;
      default:    raw = 1'b0;
    endcase
  end

  // open drain drives only while asserted; a disabled pin floats
  always_comb begin
    if (!enable) begin
      nxt_oe_n = 1'b1;
    end else if (open_drain) begin
      nxt_oe_n = ~raw;
    end else begin
      nxt_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= raw ^ invert;
      pin_oe_n <= nxt_oe_n;
    end
  end
endmodule // tso_pin_sel

// ### core/tso_top.sv
`timescale 1ns/1ns
module tso_top
  import tso_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       reg_wr_en,
  input  wire logic [tso_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tso_pkg::REG_W-1:0]  reg_wr_data,
  output logic      [tso_pkg::REG_W-1:0]  reg_rd_data,
  input  wire logic                       standby,
  input  wire logic                       slot_a_en,
  input  wire logic                       slot_b_en,
  input  wire logic                       slot_a_busy,
  input  wire logic                       slot_b_busy,
  input  wire logic                       led_pulse_a,
  input  wire logic                       led_pulse_b,
  input  wire logic                       data_wr_a,
  input  wire logic                       data_wr_b,
  input  wire logic                       sample_start,
  input  wire logic                       sample_done,
  input  wire logic                       irq_level,
  input  wire logic                       osc_32k,
  output logic                            pin_a_out,
  output logic                            pin_a_oe_n,
  output logic                            pin_b_out,
  output logic                            pin_b_oe_n
);
  import tso_pkg::*;

  logic [REG_W-1:0] sel_reg_ff;
  logic [REG_W-1:0] cfg_reg_ff;
  logic [REG_W-1:0] nxt_rd_data;
  logic             osc_meta_ff;
  logic             osc_sync_ff;
  tso_win_t         win_state_ff;
  logic             busy_a_d_ff;
  logic             busy_b_d_ff;
  logic             wr_a_ff;
  logic             wr_b_ff;
  logic             half_ff;
  logic             first_rise;
  logic             last_fall;
  logic [SEL_W-1:0] pin_sel [NPINS];
  logic [2:0]       pin_cfg [NPINS];
  logic [NPINS-1:0] pin_out_v;
  logic [NPINS-1:0] pin_oe_n_v;

  tso_if tif ();

  // register writes; reserved bits stay zero
  always_ff @(posedge clock) begin
    if (rst) begin
      sel_reg_ff <= SEL_REG_RST;
      cfg_reg_ff <= CFG_REG_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_SELECT) begin
        sel_reg_ff <= reg_wr_data & SEL_REG_MASK;
      end
      if (reg_addr == ADDR_PIN_CFG) begin
        cfg_reg_ff <= reg_wr_data & CFG_REG_MASK;
      end
    end
  end

  always_comb begin
    case (reg_addr)
      ADDR_SELECT:  nxt_rd_data = sel_reg_ff;
      ADDR_PIN_CFG: nxt_rd_data = cfg_reg_ff;
      default:      nxt_rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rd_data <= 16'h0000;
    end else begin
      reg_rd_data <= nxt_rd_data;
    end
  end

  // the oscillator comes from another domain
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
    end else begin
      osc_meta_ff <= osc_32k;
      osc_sync_ff <= osc_meta_ff;
    end
  end

  // sample window
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_a_d_ff <= 1'b0;
      busy_b_d_ff <= 1'b0;
    end else begin
      busy_a_d_ff <= slot_a_busy;
      busy_b_d_ff <= slot_b_busy;
    end
  end

  assign first_rise = (slot_a_en & slot_a_busy & ~busy_a_d_ff) | (slot_b_en & slot_b_busy & ~busy_b_d_ff);
  // slot B, when enabled, always runs last in the sample
  assign last_fall  = slot_b_en ? (busy_b_d_ff & ~slot_b_busy) : (slot_a_en & busy_a_d_ff & ~slot_a_busy);

  always_ff @(posedge clock) begin
    if (rst) begin
      win_state_ff <= WIN_IDLE;
    end else if (standby) begin
      win_state_ff <= WIN_IDLE;
    end else begin
      case (win_state_ff)
        WIN_IDLE: begin
          if (first_rise) begin
            win_state_ff <= WIN_OPEN;
          end
        end
        WIN_OPEN: begin
          if (last_fall) begin
            win_state_ff <= WIN_IDLE;
          end
        end
        default: win_state_ff <= WIN_IDLE;
      endcase
    end
  end

  // data written flags; a write in the sample_start cycle still counts, one during standby is lost
  always_ff @(posedge clock) begin
    if (rst || standby) begin
      wr_a_ff <= 1'b0;
      wr_b_ff <= 1'b0;
    end else begin
      if (data_wr_a) begin
        wr_a_ff <= 1'b1;
      end else if (sample_start) begin
        wr_a_ff <= 1'b0;
      end
      if (data_wr_b) begin
        wr_b_ff <= 1'b1;
      end else if (sample_start) begin
        wr_b_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || standby) begin
      half_ff <= 1'b0;
    end else if (sample_done) begin
      half_ff <= ~half_ff;
    end
  end

  assign tif.sample_win = (win_state_ff == WIN_OPEN);
  assign tif.led_a      = led_pulse_a;
  assign tif.led_b      = led_pulse_b;
  assign tif.wr_a       = wr_a_ff;
  assign tif.wr_b       = wr_b_ff;
  assign tif.half_rate  = half_ff;
  assign tif.osc        = osc_sync_ff;
  assign tif.irq        = irq_level;

  assign pin_sel[0] = sel_reg_ff[SEL_A_LSB +: SEL_W];
  assign pin_sel[1] = sel_reg_ff[SEL_B_LSB +: SEL_W];
  assign pin_cfg[0] = cfg_reg_ff[CFG_A_LSB +: 3];
  assign pin_cfg[1] = cfg_reg_ff[CFG_B_LSB +: 3];

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    tso_pin_sel u_pin (
      .clock      (clock),
      .rst        (rst),
      .sel        (pin_sel[i]),
      .invert     (pin_cfg[i][CFG_INV]),
      .open_drain (pin_cfg[i][CFG_OD]),
      .enable     (pin_cfg[i][CFG_EN]),
      .tif        (tif.sink),
      .pin_out    (pin_out_v[i]),
      .pin_oe_n   (pin_oe_n_v[i])
    );
  end

  assign pin_a_out  = pin_out_v[0];
  assign pin_a_oe_n = pin_oe_n_v[0];
  assign pin_b_out  = pin_out_v[1];
  assign pin_b_oe_n = pin_oe_n_v[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_first_slot;
    win_state_ff == WIN_IDLE && !standby && first_rise;
  endsequence
  sequence s_last_slot_end;
    win_state_ff == WIN_OPEN && !standby && last_fall;
  endsequence
  sequence s_pin_a_plain(logic [SEL_W-1:0] code);
    sel_reg_ff[4:0] == code && cfg_reg_ff[2:0] == 3'b100;
  endsequence

  AST_WIN_OPEN: assert property (s_first_slot |=> tif.sample_win ##1 1'b1)
    else $error("window did not open at first slot start");
  AST_WIN_CLOSE: assert property (s_last_slot_end |=> !tif.sample_win)
    else $error("window did not close at last slot end");
  AST_WR_SET: assert property (data_wr_a && !standby |=> wr_a_ff && tif.wr_a)
    else $error("slot A written flag not set");
  AST_WR_CLEAR: assert property (sample_start && !data_wr_a && !data_wr_b |=> !wr_a_ff && !wr_b_ff)
    else $error("written flags not cleared at sample start");
  AST_HALF_STANDBY: assert property (standby ##1 (!standby && !sample_done) |=> !half_ff)
    else $error("half rate toggle not low after standby");
  AST_HALF_TOGGLE: assert property (!standby && sample_done |=> half_ff != $past(half_ff))
    else $error("half rate toggle missed a sample");
  AST_PIN_LOW: assert property (s_pin_a_plain(SEL_LOW) |=> !pin_a_out && !pin_a_oe_n)
    else $error("pin A not driven low");
  AST_PIN_HIGH: assert property (sel_reg_ff[12:8] == SEL_HIGH && cfg_reg_ff[10:8] == 3'b100 |=> pin_b_out)
    else $error("pin B not driven high");
  AST_LED_AB: assert property (s_pin_a_plain(SEL_LED_AB) ##0 (led_pulse_a || led_pulse_b) |=> pin_a_out)
    else $error("combined LED pulse missing on pin A");
  AST_OSC: assert property (s_pin_a_plain(SEL_OSC) |=> pin_a_out == $past(osc_sync_ff))
    else $error("oscillator copy wrong on pin A");
  AST_RESERVED: assert property (s_pin_a_plain(5'h00) |=> !pin_a_out)
    else $error("reserved code did not give inactive level");
  AST_OD_RELEASE: assert property (sel_reg_ff[4:0] == SEL_LOW && cfg_reg_ff[2:1] == 2'b11 |=> pin_a_oe_n)
    else $error("open drain pin driven while not asserted");
  AST_OD_RELEASE_B: assert property (sel_reg_ff[12:8] == SEL_LOW && cfg_reg_ff[10:9] == 2'b11 |=> pin_b_oe_n)
    else $error("open drain pin B driven while not asserted");
endmodule // tso_top

// ### verif/tso_host_model.sv
`timescale 1ns/1ns
// far-side listener on a shared line with a pull-up: a released pin reads high
module tso_host_model (
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      line
);
  assign line = pin_oe_n ? 1'b1 : pin_out;
endmodule // tso_host_model

// ### verif/test_timing_signal_output_select.sv
`timescale 1ns/1ns
module test_timing_signal_output_select;
  import tso_pkg::*;
  localparam logic [4:0] CA[4] = '{5'h05, 5'h07, 5'h10, 5'h11};
  localparam logic [4:0] CB[4] = '{5'h06, 5'h01, 5'h11, 5'h03};
  logic              clock = 1'h0, rst = 1'h1, reg_wr_en = 1'h0, standby = 1'h0;
  logic              slot_a_en = 1'h1, slot_b_en = 1'h1, slot_a_busy = 1'h0, slot_b_busy = 1'h0;
  logic              led_pulse_a = 1'h0, led_pulse_b = 1'h0, data_wr_a = 1'h0, data_wr_b = 1'h0;
  logic              sample_start = 1'h0, sample_done = 1'h0, irq_level = 1'h0, osc_32k = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [REG_W-1:0]  reg_wr_data = 16'h0000;
  logic [REG_W-1:0]  reg_rd_data;
  logic              pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, line_a, line_b;
  int                miscompares = 0;
  int                checks = 0;
  logic [31:0]       seed = 32'h0000003A;
  logic [16:0]       notes[$];
  event              look;

  tso_top dut (.clock, .rst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data, .standby, .slot_a_en,
    .slot_b_en, .slot_a_busy, .slot_b_busy, .led_pulse_a, .led_pulse_b, .data_wr_a, .data_wr_b,
    .sample_start, .sample_done, .irq_level, .osc_32k, .pin_a_out, .pin_a_oe_n, .pin_b_out, .pin_b_oe_n);
  tso_host_model host_a (.pin_out(pin_a_out), .pin_oe_n(pin_a_oe_n), .line(line_a));
  tso_host_model host_b (.pin_out(pin_b_out), .pin_oe_n(pin_b_oe_n), .line(line_b));

  initial forever #5 clock = ~clock;

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // pin level expected one edge after the inputs, for the one-cycle sources
  function logic raw(input logic [4:0] c);
    case (c)
      5'h01:   raw = irq_level;
      5'h05:   raw = led_pulse_a;
      5'h06:   raw = led_pulse_b;
      5'h07:   raw = led_pulse_a | led_pulse_b;
      5'h11:   raw = 1'h1;
      default: raw = 1'h0;
    endcase
  endfunction

  task print_verdict();
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk_reg(input logic [15:0] e);
    checks++;
    if (reg_rd_data !== e) begin
      miscompares++;
      $display("[FAIL] reg_rd_data expected %h seen %h", e, reg_rd_data);
    end
  endtask

  task chk_pin(input logic [3:0] e);
    checks++;
    if ({line_a, line_b, pin_a_oe_n, pin_b_oe_n} !== e) begin
      miscompares++;
      $display("[FAIL] lines_and_oe_n expected %h seen %h", e, {line_a, line_b, pin_a_oe_n, pin_b_oe_n});
    end
  endtask

  task cyc(input int n = 1);
    repeat (n) @(negedge clock);
  endtask

  // bit 16 marks a register note; otherwise bits 3:0 are line a, line b, oe a, oe b
  task note(input logic [16:0] v);
    notes.push_back(v);
    ->look;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'h1;
    cyc();
    reg_wr_en = 1'h0;
    // let an edge pass so a following write never re-raises the strobe in the same step
    cyc();
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    cyc();
    note({1'h1, e});
  endtask

  task sel(input logic [4:0] a, input logic [4:0] b);
    wr(ADDR_SELECT, {3'h0, b, 3'h0, a});
    cyc(2);
  endtask

  // one sample: slot a then slot b, pins checked during slot b and after the sample ends
  task sample(input logic wa, input logic wb, input logic [1:0] mid, input logic [1:0] fin);
    sample_start = 1'h1;
    slot_a_busy = 1'h1;
    cyc();
    sample_start = 1'h0;
    cyc(3);
    slot_a_busy = 1'h0;
    data_wr_a = wa;
    slot_b_busy = 1'h1;
    cyc();
    data_wr_a = 1'h0;
    cyc(2);
    note({13'h0000, mid, 2'h0});
    slot_b_busy = 1'h0;
    data_wr_b = wb;
    sample_done = 1'h1;
    cyc();
    data_wr_b = 1'h0;
    sample_done = 1'h0;
    cyc(2);
    note({13'h0000, fin, 2'h0});
  endtask

  initial begin : watch
    logic [16:0] v;
    forever begin
      @look;
      v = notes.pop_front();
      if (v[16])
        chk_reg(v[15:0]);
      else
        chk_pin(v[3:0]);
    end
  end

  initial begin
    repeat (4000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  initial begin : main
    logic [31:0] r;
    cyc(5);
    rst = 1'h0;
    rd(ADDR_SELECT, 16'h0000);
    rd(ADDR_PIN_CFG, 16'h0404);
    r = xs();
    wr(ADDR_SELECT, r[15:0]);
    rd(ADDR_SELECT, r[15:0] & 16'h1F1F);
    wr(ADDR_PIN_CFG, 16'hFFFF);
    rd(ADDR_PIN_CFG, 16'h0707);
    wr(8'h05, 16'hFFFF);
    rd(8'h05, 16'h0000);
    wr(ADDR_PIN_CFG, 16'h0404);
    for (int i = 0; i < 4; i++) begin
      sel(CA[i], CB[i]);
      repeat (6) begin
        r = xs();
        {led_pulse_a, led_pulse_b, irq_level} = r[2:0];
        cyc();
        note({13'h0000, raw(CA[i]), raw(CB[i]), 2'h0});
      end
    end
    sel(5'h02, 5'h0E);
    sample(1'h1, 1'h0, 2'h3, 2'h1);
    sel(5'h0C, 5'h0D);
    sample(1'h0, 1'h1, 2'h0, 2'h1);
    sample(1'h1, 1'h1, 2'h2, 2'h3);
    slot_b_en = 1'h0;
    sel(5'h02, 5'h10);
    sample(1'h0, 1'h0, 2'h0, 2'h0);
    slot_b_en = 1'h1;
    sel(5'h0F, 5'h10);
    // drive the toggle high first, so the clear during standby is visible
    sample(1'h0, 1'h0, 2'h0, 2'h2);
    standby = 1'h1;
    cyc(2);
    standby = 1'h0;
    cyc(2);
    note(17'h00000);
    sample(1'h0, 1'h0, 2'h0, 2'h2);
    sample(1'h0, 1'h0, 2'h2, 2'h0);
    sel(5'h13, 5'h11);
    osc_32k = 1'h1;
    cyc(4);
    note(17'h0000C);
    osc_32k = 1'h0;
    cyc(4);
    note(17'h00004);
    // pin a inverted push-pull, pin b open drain
    wr(ADDR_PIN_CFG, 16'h0605);
    sel(5'h10, 5'h10);
    note(17'h0000D);
    sel(5'h11, 5'h11);
    note(17'h00004);
    wr(ADDR_PIN_CFG, 16'h0000);
    cyc(2);
    note(17'h0000F);
    cyc();
    print_verdict();
  end
endmodule // test_timing_signal_output_select
